// ==== include/ldi_regs.vh ====
/*
 holds register offsets, command codes, field positions, reset values and timing counts of the led driver i2c slave port.
 assumes a 200 MHz ref_clk.
*/
`ifndef LDI_REGS_VH
`define LDI_REGS_VH

`define LDI_CLK_PERIOD_PS       32'd5000
`define LDI_DECODE_TIME_MS      32'd5
`define LDI_DECODE_CYCLES       ((`LDI_DECODE_TIME_MS * 32'd1000000) / (`LDI_CLK_PERIOD_PS / 32'd1000))

`define LDI_FIXED_ADDR_HI       3'b011
`define LDI_COMMON_ADDR         7'h3f

`define LDI_CMD_SECTION_SELECT  8'hfd
`define LDI_SECTION_CONTROL     8'hc0
`define LDI_SECTION_RESET       8'h00

`define LDI_REG_CONFIG          8'h06
`define LDI_REG_SHUTDOWN        8'h09
`define LDI_REG_ADDRESS         8'h0f

`define LDI_CONFIG_RESET        8'h00
`define LDI_SHUTDOWN_RESET      8'h00

`define LDI_CFG_COMMON_BIT      6
`define LDI_SHDN_RUN_BIT        0

`endif

// ==== logic/ldi_sync.v ====
/*
 two-flop synchroniser for a group of pin inputs.
 assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module ldi_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)(
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

reg [WIDTH-1:0] stage1;

always @(posedge clk)
begin
	if (rst)
	begin
		stage1 <= INIT;
		dout   <= INIT;
	end
	else
	begin
		stage1 <= din;
		dout   <= stage1;
	end
end

endmodule

// ==== logic/ldi_addr_strap.v ====
/*
 catches the address strap once after reset release, after the decode delay.
 assumes addr_code is already synchronised and steady.
*/
`timescale 1ns/1ps
`include "ldi_regs.vh"
module ldi_addr_strap #(
	parameter DECODE_CYCLES = `LDI_DECODE_CYCLES
)(
	input  wire       clk,
	input  wire       rst,
	input  wire [2:0] addr_code,
	output reg  [2:0] strap_addr,
	output reg        addr_valid
);

reg [31:0] wait_count;

always @(posedge clk)
begin
	if (rst)
	begin
		wait_count <= 32'h0;
		strap_addr <= 3'h0;
		addr_valid <= 1'b0;
	end
	else if (!addr_valid)
	begin
		if (wait_count >= DECODE_CYCLES - 1)
		begin
			strap_addr <= addr_code;
			addr_valid <= 1'b1;
		end
		else
			wait_count <= wait_count + 32'h1;
	end
end

endmodule

// ==== logic/ldi_i2c_slave.v ====
/*
 i2c slave front end of an led matrix driver: start/stop detection, address match, command pointer,
 register write and read, section select and shutdown state.
 assumes scl and sda pins are open drain with external pull-ups, and that rst is the power-on reset; the low
 hardware reset pin is synchronised and combined with rst inside this module.
*/
`timescale 1ns/1ps
`include "ldi_regs.vh"
module ldi_i2c_slave #(
	parameter DECODE_CYCLES = `LDI_DECODE_CYCLES
)(
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       hardware_reset_n_pin,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire [2:0] addr_code,
	output reg  [7:0] section_select,
	output reg  [7:0] device_configuration,
	output reg  [7:0] shutdown_and_open_short,
	output wire       display_run,
	output wire       hw_shutdown,
	output reg        reg_wr_strobe,
	output reg  [7:0] reg_wr_addr,
	output reg  [7:0] reg_wr_data,
	input  wire [7:0] ext_rd_data
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_WACK = 3'd2;
localparam ST_WBYTE = 3'd3;
localparam ST_RBYTE = 3'd4;
localparam ST_RACK = 3'd5;
localparam ST_IGNORE = 3'd6;

function addr_match;
	input [6:0] addr;
	input [2:0] strap;
	input       common_en;
	begin
		addr_match = (addr == {1'b0, `LDI_FIXED_ADDR_HI, strap}) ||
			(common_en && addr == `LDI_COMMON_ADDR);
	end
endfunction

wire [2:0] pins_s;
wire       scl_s = pins_s[0];
wire       sda_s = pins_s[1];
wire       hardware_reset_n_pin_s = pins_s[2];
wire       core_rst = rst | ~hardware_reset_n_pin_s;
wire [2:0] code_s;
wire [2:0] strap_addr;
wire       addr_valid;

ldi_sync #(.WIDTH(3), .INIT(3'b111)) u_pin_sync
(
	.clk  (ref_clk),
	.rst  (rst),
	.din  ({hardware_reset_n_pin, sda_in, scl_in}),
	.dout (pins_s)
);

ldi_sync #(.WIDTH(3), .INIT(3'b000)) u_code_sync
(
	.clk  (ref_clk),
	.rst  (rst),
	.din  (addr_code),
	.dout (code_s)
);

ldi_addr_strap #(.DECODE_CYCLES(DECODE_CYCLES)) u_strap
(
	.clk        (ref_clk),
	.rst        (core_rst),
	.addr_code  (code_s),
	.strap_addr (strap_addr),
	.addr_valid (addr_valid)
);

////////////////////////////////////////////////////////////////////////////////
reg        scl_d;
reg        sda_d;
wire       scl_rise = scl_s & ~scl_d;
wire       scl_fall = ~scl_s & scl_d;
wire       start_det = scl_s & scl_d & sda_d & ~sda_s;
wire       stop_det = scl_s & scl_d & ~sda_d & sda_s;

reg [2:0]  state;
reg [3:0]  bit_count;
reg [7:0]  shift;
reg        first_byte;
reg [7:0]  pointer;
reg        drive_low;
reg        master_nack;

wire [7:0] rx_byte = {shift[6:0], sda_s};

assign sda_out = 1'b0;
assign sda_oe = drive_low;
assign display_run = shutdown_and_open_short[`LDI_SHDN_RUN_BIT] & ~hw_shutdown;
assign hw_shutdown = ~hardware_reset_n_pin_s;

function [7:0] read_mux;
	input [7:0] ptr;
	input [7:0] section;
	input [7:0] cfg;
	input [7:0] shdn;
	input [2:0] strap;
	input [7:0] ext;
	begin
		if (ptr == `LDI_CMD_SECTION_SELECT)
			read_mux = section;
		else if (section != `LDI_SECTION_CONTROL)
			read_mux = ext;
		else if (ptr == `LDI_REG_CONFIG)
			read_mux = cfg;
		else if (ptr == `LDI_REG_SHUTDOWN)
			read_mux = shdn;
		else if (ptr == `LDI_REG_ADDRESS)
			read_mux = {4'h0, strap, 1'b0};
		else
			read_mux = ext;
	end
endfunction

wire [7:0] rd_byte = read_mux(pointer, section_select, device_configuration,
	shutdown_and_open_short, strap_addr, ext_rd_data);

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk)
begin
	if (core_rst)
	begin
		scl_d <= 1'b1;
		sda_d <= 1'b1;
	end
	else
	begin
		scl_d <= scl_s;
		sda_d <= sda_s;
	end
end

always @(posedge ref_clk)
begin
	if (core_rst)
	begin
		state <= ST_IDLE;
		bit_count <= 4'h0;
		shift <= 8'h00;
		first_byte <= 1'b0;
		pointer <= 8'h00;
		drive_low <= 1'b0;
		master_nack <= 1'b0;
		section_select <= `LDI_SECTION_RESET;
		device_configuration <= `LDI_CONFIG_RESET;
		shutdown_and_open_short <= `LDI_SHUTDOWN_RESET;
		reg_wr_strobe <= 1'b0;
		reg_wr_addr <= 8'h00;
		reg_wr_data <= 8'h00;
	end
	else
	begin
		reg_wr_strobe <= 1'b0;
		if (stop_det)
		begin
			state <= ST_IDLE;
			drive_low <= 1'b0;
		end
		else if (start_det)
		begin
			state <= addr_valid ? ST_ADDR : ST_IGNORE;
			bit_count <= 4'h0;
			drive_low <= 1'b0;
		end
		else
		begin
			case (state)
			ST_IDLE:
				drive_low <= 1'b0;
			ST_ADDR, ST_WBYTE:
			begin
				if (scl_rise)
				begin
					shift <= rx_byte;
					bit_count <= bit_count + 4'h1;
				end
				if (scl_fall && bit_count == 4'd8)
				begin
					bit_count <= 4'h0;
					if (state == ST_ADDR)
					begin
						if (addr_match(shift[7:1], strap_addr,
							device_configuration[`LDI_CFG_COMMON_BIT]))
						begin
							drive_low <= 1'b1;
							first_byte <= ~shift[0];
							state <= shift[0] ? ST_RACK : ST_WACK;
						end
						else
							state <= ST_IGNORE;
					end
					else
					begin
						drive_low <= 1'b1;
						state <= ST_WACK;
						first_byte <= 1'b0;
						if (first_byte)
							pointer <= shift;
						else if (pointer == `LDI_CMD_SECTION_SELECT)
							section_select <= shift;
						else if (section_select == `LDI_SECTION_CONTROL &&
							pointer == `LDI_REG_CONFIG)
							device_configuration <= shift;
						else if (section_select == `LDI_SECTION_CONTROL &&
							pointer == `LDI_REG_SHUTDOWN)
							shutdown_and_open_short <= shift;
						else
						begin
							reg_wr_strobe <= 1'b1;
							reg_wr_addr <= pointer;
							reg_wr_data <= shift;
						end
						if (!first_byte)
							pointer <= pointer + 8'h1;
					end
				end
			end
			ST_WACK:
				if (scl_fall)
				begin
					drive_low <= 1'b0;
					state <= ST_WBYTE;
				end
			ST_RACK:
				if (scl_fall)
				begin
					if (drive_low || !master_nack)
					begin
						shift <= rd_byte;
						drive_low <= ~rd_byte[7];
						pointer <= pointer + 8'h1;
						bit_count <= 4'h1;
						state <= ST_RBYTE;
					end
					else
					begin
						drive_low <= 1'b0;
						state <= ST_IGNORE;
					end
				end
				else if (scl_rise && !drive_low)
					master_nack <= sda_s;
			ST_RBYTE:
				if (scl_fall)
				begin
					if (bit_count == 4'd8)
					begin
						drive_low <= 1'b0;
						master_nack <= 1'b0;
						state <= ST_RACK;
					end
					else
					begin
						drive_low <= ~shift[6];
						shift <= {shift[6:0], 1'b0};
						bit_count <= bit_count + 4'h1;
					end
				end
			ST_IGNORE:
				drive_low <= 1'b0;
			default:
				state <= ST_IDLE;
			endcase
		end
	end
end

endmodule

// ==== testbench/ldi_chk.sv ====
/*
 checker for the i2c slave port, bound to ldi_i2c_slave.
 assumes sync active-high rst on ref_clk.
*/
`timescale 1ns/1ps
module ldi_chk #(
	parameter DECODE_CYCLES = 100
)(
	input wire       ref_clk,
	input wire       rst,
	input wire       hardware_reset_n_pin,
	input wire       scl_in,
	input wire       sda_out,
	input wire       sda_oe,
	input wire [7:0] section_select,
	input wire [7:0] device_configuration,
	input wire [7:0] shutdown_and_open_short,
	input wire       display_run,
	input wire       hw_shutdown,
	input wire       reg_wr_strobe
);
	integer cnt;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// cycles since reset release
	always @(posedge ref_clk)
		if (rst || !hardware_reset_n_pin)
			cnt <= 0;
		else if (cnt < DECODE_CYCLES)
			cnt <= cnt + 1;
	sequence s_ack_high;
		$rose(scl_in) && sda_oe;
	endsequence
	property p_od;
		sda_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_run;
		!shutdown_and_open_short[0] || hw_shutdown |-> !display_run;
	endproperty
	a_run: assert property (p_run) else $error("display runs in shutdown");
	property p_hw;
		!hardware_reset_n_pin [*4] |-> hw_shutdown;
	endproperty
	a_hw: assert property (p_hw) else $error("no hardware shutdown");
	property p_oe_low;
		sda_oe != $past(sda_oe) |-> !scl_in;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("sda moved with scl high");
	property p_ack;
		s_ack_high |-> sda_oe [*4];
	endproperty
	a_ack: assert property (p_ack) else $error("sda low not held");
	property p_early;
		cnt < DECODE_CYCLES |-> !sda_oe;
	endproperty
	a_early: assert property (p_early) else $error("answer before decode");
	property p_strobe;
		reg_wr_strobe |=> !reg_wr_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too long");
	property p_cfg;
		disable iff (rst || !hardware_reset_n_pin)
		device_configuration != $past(device_configuration) |-> section_select == 8'hc0;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config outside section");
endmodule
bind ldi_i2c_slave ldi_chk #(.DECODE_CYCLES(DECODE_CYCLES)) chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.hardware_reset_n_pin(hardware_reset_n_pin),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.section_select(section_select),
	.device_configuration(device_configuration),
	.shutdown_and_open_short(shutdown_and_open_short),
	.display_run(display_run),
	.hw_shutdown(hw_shutdown),
	.reg_wr_strobe(reg_wr_strobe)
);

// ==== testbench/ldi_master.sv ====
/*
 i2c bus master model with bit and byte tasks.
 assumes pull-ups on sda and scl outside.
*/
`timescale 1ns/1ps
module ldi_master (
	input  wire clk,
	input  wire sda_in,
	output reg  scl,
	output reg  sda
);
	integer i;
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task tk(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task bit_io(input b, output r);
	begin
		sda <= b;
		tk(6);
		scl <= 1'b1;
		tk(6);
		r = sda_in;
		scl <= 1'b0;
		tk(2);
	end
	endtask
	task start;
	begin
		sda <= 1'b1;
		tk(4);
		scl <= 1'b1;
		tk(6);
		sda <= 1'b0;
		tk(6);
		scl <= 1'b0;
		tk(2);
	end
	endtask
	task stop;
	begin
		sda <= 1'b0;
		tk(4);
		scl <= 1'b1;
		tk(6);
		sda <= 1'b1;
		tk(6);
	end
	endtask
	// msb first, ninth clock carries ack
	task xfer(input [7:0] d, input n, output [7:0] q, output a);
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], q[i]);
		bit_io(n, a);
	end
	endtask
endmodule

// ==== testbench/tb.sv ====
/*
 testbench for ldi_i2c_slave driven by the i2c master model.
 assumes a short decode count.
*/
`timescale 1ns/1ps
module tb;
	reg        ref_clk = 1'b0;
	reg        rst = 1'b1;
	reg        hw_n = 1'b1;
	reg  [2:0] code = 3'b101;
	wire       scl;
	wire       m_sda;
	wire       oe;
	wire       sda = m_sda & ~oe;
	wire [7:0] sec;
	wire [7:0] cfg;
	wire [7:0] shd;
	wire [7:0] wa;
	wire [7:0] wd;
	wire       run;
	wire       hws;
	integer    err_count = 0;
	integer    cmp_count = 0;
	reg  [7:0] q;
	reg        a;
	always #2.5 ref_clk = ~ref_clk;
	ldi_i2c_slave #(.DECODE_CYCLES(100)) uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.hardware_reset_n_pin(hw_n),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(),
		.sda_oe(oe),
		.addr_code(code),
		.section_select(sec),
		.device_configuration(cfg),
		.shutdown_and_open_short(shd),
		.display_run(run),
		.hw_shutdown(hws),
		.reg_wr_strobe(),
		.reg_wr_addr(wa),
		.reg_wr_data(wd),
		.ext_rd_data(8'h5a)
	);
	ldi_master m (
		.clk(ref_clk),
		.sda_in(sda),
		.scl(scl),
		.sda(m_sda)
	);
	task chk(input [63:0] n, input [7:0] e, input [7:0] g);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			$display("Error %0s exp %h got %h", n, e, g);
			err_count = err_count + 1;
		end
	end
	endtask
	task addr(input [7:0] ad, input e);
	begin
		m.start;
		m.xfer(ad, 1'b1, q, a);
		chk("ack", {7'h0, e}, {7'h0, a});
	end
	endtask
	task wr(input [7:0] ad, input [7:0] p, input [7:0] d);
	begin
		addr(ad, 1'b0);
		m.xfer(p, 1'b1, q, a);
		chk("ack", 8'h0, {7'h0, a});
		m.xfer(d, 1'b1, q, a);
		chk("ack", 8'h0, {7'h0, a});
		m.stop;
	end
	endtask
	task setp(input [7:0] p);
	begin
		addr(8'h3a, 1'b0);
		m.xfer(p, 1'b1, q, a);
		addr(8'h3b, 1'b0);
	end
	endtask
	task wrap_up;
	begin
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count = err_count + 1;
		wrap_up;
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("regs", 8'h0, sec | cfg | shd);
		addr(8'h3a, 1'b1);
		m.stop;
		addr(8'h7e, 1'b1);
		m.stop;
		wr(8'h3a, 8'hfd, 8'hc0);
		chk("sec", 8'hc0, sec);
		wr(8'h3a, 8'h06, 8'h40);
		chk("cfg", 8'h40, cfg);
		wr(8'h7e, 8'h09, 8'h01);
		chk("run", 8'h1, {7'h0, run});
		wr(8'h3a, 8'h20, 8'h11);
		chk("wa", 8'h20, wa);
		chk("wd", 8'h11, wd);
		code <= 3'b010;
		addr(8'h34, 1'b1);
		m.stop;
		setp(8'h06);
		m.xfer(8'hff, 1'b0, q, a);
		chk("rd0", 8'h40, q);
		m.xfer(8'hff, 1'b1, q, a);
		chk("rd1", 8'h5a, q);
		chk("rel", 8'h1, {7'h0, a});
		m.stop;
		setp(8'h0f);
		m.xfer(8'hff, 1'b1, q, a);
		chk("strap", 8'h0a, q);
		m.stop;
		wr(8'h3a, 8'h09, 8'h00);
		chk("run", 8'h0, {7'h0, run});
		hw_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("hws", 8'h1, {7'h0, hws});
		hw_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("sec", 8'h0, sec);
		wrap_up;
	end
endmodule
